//--- verilog/mcuex_pkg.sv
package mcuex_pkg;
  localparam int PC_W = 11;
  localparam int INSN_W = 14;
  localparam int RADDR_W = 7;
  localparam logic [10:0] TRAP_VECTOR = 11'h001;
  localparam logic [3:0] FPAGE_MIN = 4'h5;
  localparam logic [3:0] FPAGE_MAX = 4'hF;
  localparam int STACK_DEPTH = 8;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [10:0] PC_RESET = 11'h000;
  // apb register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_INSN = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_PC = 12'h00C;
  localparam logic [11:0] ADDR_ACC = 12'h010;
  localparam logic [11:0] ADDR_PTRS = 12'h014;
  localparam logic [11:0] ADDR_RDATA = 12'h018;
  // status field positions
  localparam int ST_Z = 0;
  localparam int ST_C = 1;
  localparam int ST_GIE = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_FPERR = 4;
  // opcode encodings (14-bit words, chosen)
  localparam logic [5:0] OP_NOP = 6'h00;
  localparam logic [5:0] OP_CLEAR_REGISTER = 6'h01;
  localparam logic [5:0] OP_COMPLEMENT_REGISTER = 6'h02;
  localparam logic [5:0] OP_COMPARE_ACC_REGISTER = 6'h03;
  localparam logic [5:0] OP_DAA = 6'h04;
  localparam logic [5:0] OP_DECREMENT_REGISTER = 6'h05;
  localparam logic [5:0] OP_INCREMENT_REGISTER = 6'h06;
  localparam logic [5:0] OP_DECSZ = 6'h07;
  localparam logic [5:0] OP_INCSZ = 6'h08;
  localparam logic [5:0] OP_IDIS = 6'h09;
  localparam logic [5:0] OP_IEN = 6'h0A;
  localparam logic [5:0] OP_AJMP = 6'h0B;
  localparam logic [5:0] OP_TRAP = 6'h0C;
  localparam logic [5:0] OP_ORR = 6'h0D;
  localparam logic [5:0] OP_ORI = 6'h0E;
  localparam logic [5:0] OP_FWR = 6'h0F;
  localparam logic [5:0] OP_FRD = 6'h10;
  localparam logic [5:0] OP_LDI = 6'h11;
  localparam logic [5:0] OP_STA = 6'h12;
  localparam logic [5:0] OP_MOVE_REGISTER = 6'h13;
  localparam logic [5:0] OP_RETL = 6'h14;
  localparam logic [1:0] OP_SJMP = 2'h2;
  localparam logic [1:0] OP_LJMP = 2'h3;
  // long call owns the otherwise unused 0x18-0x1F block of [13:8]
  localparam logic [2:0] OP_LONG_CALL = 3'h3;
  typedef enum logic [1:0] {MX_IDLE, MX_WAIT, MX_FLUSH} mcuex_state_e;
endpackage

//--- verilog/mcuex_alu.sv
`timescale 1ns/1ns
module mcuex_alu (
  // operands
  input wire logic [5:0] op,
  input wire logic [7:0] acc,
  input wire logic [7:0] rval,
  input wire logic [7:0] lit,
  input wire logic cin,
  // results
  output logic [7:0] res,
  output logic cout
);
  import mcuex_pkg::*;
  logic [8:0] sum;
  logic [8:0] adj;
  always_comb begin
    sum = {1'b0, rval} + {1'b0, ~acc} + 9'h001;
    adj = {1'b0, acc};
    res = 8'h00;
    cout = cin;
    case (op)
      OP_CLEAR_REGISTER: res = 8'h00;
      OP_COMPLEMENT_REGISTER: res = ~rval;
      OP_COMPARE_ACC_REGISTER: begin
        res = sum[7:0];
        cout = sum[8];
      end
      OP_DAA: begin
        // packed decimal fixup after an add
        if (adj[3:0] > 4'h9) begin
          adj = adj + 9'h006;
        end
        if (cin || adj[8:4] > 5'h09) begin
          adj = adj + 9'h060;
        end
        res = adj[7:0];
        cout = cin | adj[8];
      end
      OP_DECREMENT_REGISTER, OP_DECSZ: res = rval - 8'h01;
      OP_INCREMENT_REGISTER, OP_INCSZ: res = rval + 8'h01;
      OP_ORR: res = acc | rval;
      OP_ORI: res = acc | lit;
      OP_MOVE_REGISTER: res = rval;
      default: res = 8'h00;
    endcase
  end
endmodule

//--- verilog/mcuex_core.sv
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
// Summary of operation
// - clear writes zero to register and sets zero flag
// - destination bit 0 goes to accumulator, 1 back to register
// - complement inverts register to destination, updates zero flag
// - compare computes register minus accumulator, updates only zero and carry
// - decimal adjust converts accumulator to packed decimal, touching only carry
// - decrement subtracts one to destination, updates zero flag
// - increment adds one, FF wraps to zero with zero flag
// - decrement-skip squashes next instruction on zero, two cycles
// - increment-skip squashes next instruction on zero, two cycles
// - interrupt disable clears global enable in one cycle
// - interrupt enable sets global enable in one cycle
// - short jump loads nine bits, upper two from high buffer
// - indexed jump takes table pointer high and accumulator, two cycles
// - software trap pushes pc plus one, jumps to 001, three cycles
// - F page moves copy accumulator out or in, index 5 to 15
// - long call pushes pc plus one, loads 11-bit target, two cycles
// - long jump loads 11-bit target without stack, two cycles
// - load literal puts immediate in accumulator, no flags
// - store accumulator copies to register, no flags
// - move copies register to destination and updates zero flag
// - return with literal loads accumulator, pops pc, two cycles
// - carry set means carry out or no borrow
module mcuex_core #(
  parameter int DEPTH = mcuex_pkg::STACK_DEPTH
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data register file
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  input wire logic [7:0] reg_rdata,
  // f page special registers
  output logic [3:0] fpage_addr,
  output logic [7:0] fpage_wdata,
  output logic fpage_we,
  input wire logic [7:0] fpage_rdata,
  // status
  output logic global_irq_enable,
  output logic [10:0] pc
);
  import mcuex_pkg::*;

  function automatic logic is_flush_op(input logic [13:0] w);
    is_flush_op = (w[13:12] == OP_SJMP) || (w[13:12] == OP_LJMP) || (w[13:11] == OP_LONG_CALL)
      || (w[13:8] == OP_AJMP) || (w[13:8] == OP_RETL);
  endfunction

  logic [13:0] insn_ff;
  logic [7:0] acc_ff;
  logic z_ff;
  logic c_ff;
  logic gie_ff;
  logic fperr_ff;
  logic [10:0] pc_ff;
  logic [2:0] pc_high_buffer_ff;
  logic [2:0] table_high_pointer_ff;
  logic [7:0] rdata_ff;
  logic [10:0] stack_ff [DEPTH];
  logic [$clog2(DEPTH)-1:0] sp_ff;
  logic [1:0] cyc_ff;
  logic [1:0] need_ff;
  mcuex_state_e state_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [6:0] reg_addr_ff;
  logic [7:0] reg_wdata_ff;
  logic reg_we_ff;
  logic [3:0] fpage_addr_ff;
  logic [7:0] fpage_wdata_ff;
  logic fpage_we_ff;

  logic wr_en;
  logic rd_en;
  logic go;
  logic [5:0] op;
  logic dest_reg;
  logic [7:0] lit;
  logic [7:0] alu_res;
  logic alu_c;
  logic [10:0] pc_inc;
  logic [10:0] nxt_pc;
  logic [7:0] nxt_acc;
  logic nxt_z;
  logic nxt_c;
  logic nxt_gie;
  logic nxt_push;
  logic nxt_pop;
  logic [1:0] nxt_need;
  logic nxt_rwe;
  logic [7:0] nxt_rwd;
  logic nxt_fwe;
  logic nxt_ferr;
  logic legal_f;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  // an execute is taken at the write to the instruction register while idle
  assign go = wr_en && paddr == ADDR_INSN && state_ff == MX_IDLE;
  assign op = pwdata[13:8];
  assign dest_reg = pwdata[7];
  assign lit = pwdata[7:0];
  assign pc_inc = pc_ff + 11'h001;
  assign legal_f = pwdata[3:0] >= FPAGE_MIN && pwdata[3:0] <= FPAGE_MAX;

  // register operand is the file read of the addressed register, settled before go
  mcuex_alu u_alu (
    .op(op),
    .acc(acc_ff),
    .rval(reg_rdata),
    .lit(lit),
    .cin(c_ff),
    .res(alu_res),
    .cout(alu_c)
  );

  always_comb begin
    nxt_pc = pc_inc;
    nxt_acc = acc_ff;
    nxt_z = z_ff;
    nxt_c = c_ff;
    nxt_gie = gie_ff;
    nxt_push = 1'b0;
    nxt_pop = 1'b0;
    nxt_need = 2'h1;
    nxt_rwe = 1'b0;
    nxt_rwd = alu_res;
    nxt_fwe = 1'b0;
    nxt_ferr = 1'b0;
    if (pwdata[13:12] == OP_SJMP) begin
      nxt_pc = {pc_high_buffer_ff[2:1], pwdata[8:0]};
      nxt_need = 2'h2;
    end else if (pwdata[13:12] == OP_LJMP) begin
      nxt_pc = pwdata[10:0];
      nxt_need = 2'h2;
    end else if (pwdata[13:11] == OP_LONG_CALL) begin
      nxt_pc = pwdata[10:0];
      nxt_push = 1'b1;
      nxt_need = 2'h2;
    end else begin
      case (op)
        OP_CLEAR_REGISTER: begin
          nxt_rwe = 1'b1;
          nxt_z = 1'b1;
        end
        OP_COMPLEMENT_REGISTER, OP_DECREMENT_REGISTER, OP_INCREMENT_REGISTER, OP_ORR, OP_MOVE_REGISTER, OP_DECSZ, OP_INCSZ: begin
          if (dest_reg) begin
            nxt_rwe = 1'b1;
          end else begin
            nxt_acc = alu_res;
          end
          // zero flag, skip forms leave it
          if (op != OP_DECSZ && op != OP_INCSZ) begin
            nxt_z = alu_res == 8'h00;
          end
          if ((op == OP_DECSZ || op == OP_INCSZ) && alu_res == 8'h00) begin
            nxt_pc = pc_ff + 11'h002;
            nxt_need = 2'h2;
          end
        end
        OP_COMPARE_ACC_REGISTER: begin
          nxt_z = alu_res == 8'h00;
          nxt_c = alu_c;
        end
        OP_DAA: begin
          nxt_acc = alu_res;
          nxt_c = alu_c;
        end
        OP_IDIS: nxt_gie = 1'b0;
        OP_IEN: nxt_gie = 1'b1;
        OP_AJMP: begin
          nxt_pc = {table_high_pointer_ff, acc_ff};
          nxt_need = 2'h2;
        end
        OP_TRAP: begin
          nxt_pc = TRAP_VECTOR;
          nxt_push = 1'b1;
          nxt_need = 2'h3;
        end
        OP_ORI: begin
          nxt_acc = alu_res;
          nxt_z = alu_res == 8'h00;
        end
        OP_FWR: begin
          nxt_fwe = legal_f;
          nxt_ferr = !legal_f;
        end
        OP_FRD: begin
          if (legal_f) begin
            nxt_acc = fpage_rdata;
          end
          nxt_ferr = !legal_f;
        end
        OP_LDI: nxt_acc = lit;
        OP_STA: begin
          nxt_rwe = 1'b1;
          nxt_rwd = acc_ff;
        end
        OP_RETL: begin
          nxt_acc = lit;
          nxt_pop = 1'b1;
          nxt_pc = stack_ff[sp_ff - 1'b1];
          nxt_need = 2'h2;
        end
        default: nxt_need = 2'h1;
      endcase
    end
  end

  // execution state and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_ff <= PC_RESET;
      acc_ff <= ACC_RESET;
      z_ff <= 1'b0;
      c_ff <= 1'b0;
      gie_ff <= 1'b0;
      fperr_ff <= 1'b0;
      insn_ff <= 14'h0000;
      sp_ff <= '0;
    end else if (go) begin
      pc_ff <= nxt_pc;
      acc_ff <= nxt_acc;
      z_ff <= nxt_z;
      c_ff <= nxt_c;
      gie_ff <= nxt_gie;
      fperr_ff <= nxt_ferr;
      insn_ff <= pwdata[13:0];
      if (nxt_push) begin
        sp_ff <= sp_ff + 1'b1;
      end else if (nxt_pop) begin
        sp_ff <= sp_ff - 1'b1;
      end
    end
  end

  // return stack, wraps when overfilled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        stack_ff[i] <= PC_RESET;
      end
    end else if (go && nxt_push) begin
      stack_ff[sp_ff] <= pc_inc;
    end
  end

  // software-held pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_high_buffer_ff <= 3'h0;
      table_high_pointer_ff <= 3'h0;
    end else if (wr_en && paddr == ADDR_PTRS) begin
      pc_high_buffer_ff <= pwdata[2:0];
      table_high_pointer_ff <= pwdata[10:8];
    end
  end

  // multicycle occupancy; extra cycles stand for the flushed prefetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= MX_IDLE;
      cyc_ff <= 2'h0;
      need_ff <= 2'h0;
    end else begin
      case (state_ff)
        MX_IDLE: begin
          if (go && nxt_need != 2'h1) begin
            state_ff <= MX_FLUSH;
            need_ff <= nxt_need;
            cyc_ff <= 2'h1;
          end
        end
        MX_FLUSH: begin
          if (cyc_ff + 2'h1 >= need_ff) begin
            state_ff <= MX_IDLE;
          end
          cyc_ff <= cyc_ff + 2'h1;
        end
        default: state_ff <= MX_IDLE;
      endcase
    end
  end

  // register file and f page strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_we_ff <= 1'b0;
      reg_wdata_ff <= 8'h00;
      reg_addr_ff <= 7'h00;
      fpage_we_ff <= 1'b0;
      fpage_wdata_ff <= 8'h00;
      fpage_addr_ff <= 4'h0;
    end else begin
      reg_we_ff <= go && nxt_rwe;
      fpage_we_ff <= go && nxt_fwe;
      if (go) begin
        reg_wdata_ff <= nxt_rwd;
        fpage_wdata_ff <= acc_ff;
        fpage_addr_ff <= pwdata[3:0];
      end
      if (wr_en && paddr == ADDR_CTRL) begin
        reg_addr_ff <= pwdata[6:0];
      end else if (go && op != OP_FWR && op != OP_FRD) begin
        reg_addr_ff <= pwdata[6:0];
      end
    end
  end

  // apb slave, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && paddr > ADDR_RDATA;
      rdata_ff <= reg_rdata;
      prdata_ff <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          ADDR_CTRL: prdata_ff <= {25'h0, reg_addr_ff};
          ADDR_INSN: prdata_ff <= {18'h0, insn_ff};
          ADDR_STATUS: prdata_ff <= {27'h0, fperr_ff, state_ff != MX_IDLE, gie_ff, c_ff, z_ff};
          ADDR_PC: prdata_ff <= {21'h0, pc_ff};
          ADDR_ACC: prdata_ff <= {24'h0, acc_ff};
          ADDR_PTRS: prdata_ff <= {21'h0, table_high_pointer_ff, 5'h0, pc_high_buffer_ff};
          ADDR_RDATA: prdata_ff <= {24'h0, rdata_ff};
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign reg_addr = reg_addr_ff;
  assign reg_wdata = reg_wdata_ff;
  assign reg_we = reg_we_ff;
  assign fpage_addr = fpage_addr_ff;
  assign fpage_wdata = fpage_wdata_ff;
  assign fpage_we = fpage_we_ff;
  assign global_irq_enable = gie_ff;
  assign pc = pc_ff;
endmodule

//--- dv/mcuex_core_properties.sv
`timescale 1ns/1ns
module mcuex_core_properties
  import mcuex_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // execution side
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic fpage_we,
  input wire logic global_irq_enable,
  input wire logic [10:0] pc
);
  logic go;
  logic [5:0] op;
  logic dst;
  // an instruction word accepted on the bus
  assign go = psel && penable && pready && pwrite && paddr == ADDR_INSN;
  assign op = pwdata[13:8];
  assign dst = op inside {OP_COMPLEMENT_REGISTER, OP_DECREMENT_REGISTER, OP_INCREMENT_REGISTER, OP_ORR, OP_MOVE_REGISTER};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wait_one_a:
    assert property (psel && !penable |=> pready) else $error("pready late");
  err_range_a:
    assert property (pready && pslverr |-> paddr > ADDR_RDATA) else $error("bad slverr");
  clear_zero_a:
    assert property (go && op == OP_CLEAR_REGISTER |=> reg_we && reg_wdata == 8'h00
      && reg_addr == $past(pwdata[6:0])) else $error("clear not written");
  store_acc_a:
    assert property (go && op == OP_STA |=> reg_we && reg_addr == $past(pwdata[6:0]))
      else $error("store not written");
  dest_acc_a:
    assert property (go && dst && !pwdata[7] |=> !reg_we) else $error("acc dest wrote reg");
  irq_on_a:
    assert property (go && op == OP_IEN |=> global_irq_enable) else $error("enable lost");
  irq_off_a:
    assert property (go && op == OP_IDIS |=> !global_irq_enable) else $error("disable lost");
  long_jump_a:
    assert property (go && pwdata[13:12] == OP_LJMP |=> pc == $past(pwdata[10:0]))
      else $error("long jump target");
  long_call_a:
    assert property (go && pwdata[13:11] == OP_LONG_CALL |=> pc == $past(pwdata[10:0]))
      else $error("long call target");
  trap_vector_a:
    assert property (go && op == OP_TRAP |=> pc == TRAP_VECTOR) else $error("trap vector");
  fpage_write_a:
    assert property (go && op == OP_FWR |=> fpage_we == ($past(pwdata[3:0]) >= FPAGE_MIN))
      else $error("fpage write");
  nop_step_a:
    assert property (go && op == OP_NOP |=> pc == $past(pc) + 11'h001) else $error("nop step");
  cover property (go && op == OP_INCSZ);
  cover property (go && op == OP_RETL);
  cover property (pready && pslverr);
endmodule

bind mcuex_core mcuex_core_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .reg_addr, .reg_wdata, .reg_we, .fpage_we,
  .global_irq_enable, .pc);

//--- dv/mcuex_core_test.sv
`timescale 1ns/1ns
module mcuex_core_test;
  import mcuex_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, reg_we, fpage_we, global_irq_enable, e;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, fpage_wdata, reg_rdata, fpage_rdata;
  logic [3:0] fpage_addr;
  logic [10:0] pc;
  logic [7:0] rf [128];
  logic [7:0] fp [16];
  logic [7:0] mrf [128];
  logic [7:0] mfp [16];
  logic [7:0] macc = 8'h00;
  logic mz = 0, mc = 0, mgie = 0, mferr = 0;
  logic [10:0] mpc = 11'h000;
  logic [2:0] hb = 3'h6, tp = 3'h5;
  logic [10:0] stk [$];
  logic [5:0] ops [15] = '{OP_NOP, OP_CLEAR_REGISTER, OP_COMPLEMENT_REGISTER, OP_COMPARE_ACC_REGISTER, OP_DECREMENT_REGISTER, OP_INCREMENT_REGISTER, OP_DECSZ,
    OP_INCSZ, OP_IDIS, OP_IEN, OP_ORR, OP_ORI, OP_MOVE_REGISTER, OP_STA, OP_LDI};
  int n_fail = 0, check_count = 0, k;
  int seed = 32'he1f5c006;

  always #50 pclk = ~pclk;
  // register file and f page stand beside the core, read combinationally
  assign reg_rdata = rf[reg_addr];
  assign fpage_rdata = fp[pwdata[3:0]];
  always @(posedge pclk) begin
    if (reg_we) rf[reg_addr] <= reg_wdata;
    if (fpage_we) fp[fpage_addr] <= fpage_wdata;
  end

  mcuex_core i_mcuex_core (.*);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // idle edge first so psel never falls and rises in one time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_fail++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic model(input logic [13:0] w);
    logic [7:0] r;
    logic [7:0] res;
    logic [5:0] op;
    bit dst;
    r = mrf[w[6:0]];
    op = w[13:8];
    dst = op inside {OP_COMPLEMENT_REGISTER, OP_DECREMENT_REGISTER, OP_INCREMENT_REGISTER, OP_DECSZ, OP_INCSZ, OP_ORR, OP_MOVE_REGISTER};
    mpc = mpc + 11'h001;
    case (op)
      OP_CLEAR_REGISTER: res = 8'h00;
      OP_COMPLEMENT_REGISTER: res = ~r;
      OP_DECREMENT_REGISTER, OP_DECSZ: res = r - 8'h01;
      OP_INCREMENT_REGISTER, OP_INCSZ: res = r + 8'h01;
      OP_ORR: res = r | macc;
      OP_ORI: res = w[7:0] | macc;
      default: res = r;
    endcase
    if (w[13:12] == OP_SJMP) mpc = {hb[2:1], w[8:0]};
    if (w[13:12] == OP_LJMP) mpc = w[10:0];
    if (w[13:11] == OP_LONG_CALL) begin
      stk.push_back(mpc);
      mpc = w[10:0];
    end
    mferr = (op inside {OP_FWR, OP_FRD}) && w[3:0] < FPAGE_MIN;
    if ((op inside {OP_CLEAR_REGISTER, OP_ORI}) || (dst && !(op inside {OP_DECSZ, OP_INCSZ})))
      mz = res == 8'h00;
    if ((op inside {OP_DECSZ, OP_INCSZ}) && res == 8'h00) mpc = mpc + 11'h001;
    if (op == OP_CLEAR_REGISTER || (dst && w[7])) mrf[w[6:0]] = res;
    if (op == OP_ORI || (dst && !w[7])) macc = res;
    case (op)
      OP_COMPARE_ACC_REGISTER: {mc, mz} = {r >= macc, r == macc};
      OP_IDIS: mgie = 1'b0;
      OP_IEN: mgie = 1'b1;
      OP_AJMP: mpc = {tp, macc};
      OP_FWR: if (w[3:0] >= FPAGE_MIN) mfp[w[3:0]] = macc;
      OP_FRD: if (w[3:0] >= FPAGE_MIN) macc = mfp[w[3:0]];
      OP_LDI: macc = w[7:0];
      OP_STA: mrf[w[6:0]] = macc;
      OP_TRAP: begin
        stk.push_back(mpc);
        mpc = TRAP_VECTOR;
      end
      OP_RETL: begin
        macc = w[7:0];
        mpc = stk.pop_back();
      end
      OP_DAA: begin
        res = macc + ((macc[3:0] > 4'h9) ? 8'h06 : 8'h00);
        mc = macc > 8'h99 || mc;
        macc = res + (mc ? 8'h60 : 8'h00);
      end
      default: ;
    endcase
  endtask

  task automatic ex(input logic [13:0] w);
    int n;
    apb(1'b1, ADDR_CTRL, {25'h0, w[6:0]});
    apb(1'b1, ADDR_INSN, {18'h0, w});
    model(w);
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 9);
    chk(q & 32'h1F, {27'h0, mferr, 1'b0, mgie, mc, mz});
    apb(1'b0, ADDR_PC, 32'h0);
    chk(q, {21'h0, mpc});
    apb(1'b0, ADDR_ACC, 32'h0);
    chk(q, {24'h0, macc});
    chk({24'h0, rf[w[6:0]]}, {24'h0, mrf[w[6:0]]});
    chk({24'h0, fp[w[3:0]]}, {24'h0, mfp[w[3:0]]});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    n_fail++;
    test_done;
  end

  initial begin
    foreach (rf[i]) rf[i] = 8'($random(seed));
    foreach (fp[i]) fp[i] = 8'($random(seed));
    mrf = rf;
    mfp = fp;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    ex({OP_NOP, 8'h00});
    apb(1'b1, ADDR_PTRS, 32'h0000_0506);
    apb(1'b0, 12'h01C, 32'h0);
    chk({31'h0, e}, 32'h1);
    // wrap and skip boundaries on one register
    ex({OP_LDI, 8'hFF});
    ex({OP_STA, 8'h10});
    ex({OP_INCSZ, 8'h90});
    ex({OP_INCREMENT_REGISTER, 8'h90});
    ex({OP_DECSZ, 8'h90});
    ex({OP_DECREMENT_REGISTER, 8'h90});
    $display("test boundaries done");
    // every listed code once, then random mixes
    for (int i = 0; i < 60; i++) begin
      k = i < 15 ? i : $unsigned($random(seed)) % 15;
      ex({ops[k], 8'($random(seed))});
    end
    $display("test random done");
    ex({OP_LDI, 8'h4D});
    ex({OP_STA, 8'h22});
    ex({OP_LDI, 8'h4E});
    ex({OP_COMPARE_ACC_REGISTER, 8'h22});
    ex({OP_LDI, 8'h4D});
    ex({OP_DAA, 8'h00});
    ex({OP_SJMP, 3'h0, 9'h1A5});
    ex({OP_LJMP, 1'b0, 11'h7FF});
    ex({OP_AJMP, 8'h00});
    ex({OP_LONG_CALL, 11'h2C3});
    ex({OP_TRAP, 8'h00});
    ex({OP_RETL, 8'h5A});
    ex({OP_RETL, 8'hA5});
    ex({OP_FWR, 8'h05});
    ex({OP_FWR, 8'h0F});
    ex({OP_FWR, 8'h04});
    ex({OP_FRD, 8'h09});
    $display("test branches done");
    test_done;
  end
endmodule
